// [design/aerr_regs.sv]
// Advanced error reporting header plus uncorrectable status and mask registers.
// Assumes a dword configuration access port from the PCIe core and one-cycle
// detection pulses from the transaction, link and flow-control logic.
`default_nettype none

module aerr_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic pcie_reset_n,
  input wire logic global_reset_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [aerr_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [aerr_pkg::BE_W-1:0] cfg_be,
  input wire logic [aerr_pkg::DATA_W-1:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_hit,
  output logic [aerr_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic unsupported_request_det,
  input wire logic end_to_end_crc_det,
  input wire logic malformed_packet_det,
  input wire logic credit_overflow_det,
  input wire logic unexpected_completion_det,
  input wire logic completer_abort_det,
  input wire logic completion_timeout_det,
  input wire logic flow_control_protocol_det,
  input wire logic poisoned_packet_det,
  input wire logic link_protocol_det,
  output logic fundamental_reset_n,
  output logic [aerr_pkg::DATA_W-1:0] error_report,
  output logic [aerr_pkg::DATA_W-1:0] error_flags
);
  import aerr_pkg::*;

  // ----------------------------------------------------------------------
  // Fundamental reset
  // ----------------------------------------------------------------------
  // Either pin asserts it; three stages, level moves once stages 2 and 3 agree.
  // Deliberately untouched by the hot reset so sticky bits survive it.
  wire logic fund_raw_n = pcie_reset_n & global_reset_n;
  logic [2:0] fund_sync_reg;
  logic fund_n_reg;
  wire logic fund_agree = fund_sync_reg[1] == fund_sync_reg[2];

  always_ff @(posedge clk) begin
    fund_sync_reg <= {fund_sync_reg[1:0], fund_raw_n};
  end

  always_ff @(posedge clk) begin
    if (fund_agree) begin
      fund_n_reg <= fund_sync_reg[2];
    end
  end

  assign fundamental_reset_n = fund_n_reg;

  // ----------------------------------------------------------------------
  // Detection inputs placed at their status bit positions
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] detect_vec;

  always_comb begin
    detect_vec = ZERO_WORD;
    detect_vec[UNSUPPORTED_REQUEST_BIT] = unsupported_request_det;
    detect_vec[END_TO_END_CRC_BIT] = end_to_end_crc_det;
    detect_vec[MALFORMED_PACKET_BIT] = malformed_packet_det;
    detect_vec[CREDIT_OVERFLOW_BIT] = credit_overflow_det;
    detect_vec[UNEXPECTED_COMPLETION_BIT] = unexpected_completion_det;
    detect_vec[COMPLETER_ABORT_BIT] = completer_abort_det;
    detect_vec[COMPLETION_TIMEOUT_BIT] = completion_timeout_det;
    detect_vec[FLOW_CONTROL_PROTOCOL_BIT] = flow_control_protocol_det;
    detect_vec[POISONED_PACKET_BIT] = poisoned_packet_det;
    detect_vec[LINK_PROTOCOL_BIT] = link_protocol_det;
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic dword_match(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] ofs);
    dword_match = a[ADDR_W-1:DWORD_LSB] == ofs[ADDR_W-1:DWORD_LSB];
  endfunction : dword_match

  // Byte enables widened to a bit mask
  function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
    lane_mask = {{LANE_W{be[3]}}, {LANE_W{be[2]}}, {LANE_W{be[1]}}, {LANE_W{be[0]}}};
  endfunction : lane_mask

  wire logic sel_header = dword_match(cfg_addr, CAP_ID_OFS);
  wire logic sel_flags = dword_match(cfg_addr, FLAGS_OFS);
  wire logic sel_masks = dword_match(cfg_addr, MASKS_OFS);
  wire logic sel_any = sel_header | sel_flags | sel_masks;
  // Writes are dropped while the fundamental reset holds the bank cleared
  wire logic wr_ok = cfg_req & cfg_we & fund_n_reg;
  wire logic [DATA_W-1:0] be_bits = lane_mask(cfg_be);
  wire logic [DATA_W-1:0] wr_bits = cfg_wdata & be_bits & IMPL_BITS;

  // ----------------------------------------------------------------------
  // Flag and mask bank
  // ----------------------------------------------------------------------
  aerr_flag_if fif ();

  assign fif.fund_clear = ~fund_n_reg;
  assign fif.detect = detect_vec & IMPL_BITS;
  // Only a written one clears; a written zero leaves the flag alone
  assign fif.clear_ones = (wr_ok & sel_flags) ? wr_bits : ZERO_WORD;
  assign fif.mask_wen = (wr_ok & sel_masks) ? (be_bits & IMPL_BITS) : ZERO_WORD;
  assign fif.mask_wdata = wr_bits;

  aerr_flag_bank u_bank (
    .clk(clk),
    .fb(fif.bank)
  );

  assign error_flags = fif.flags;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Header is constant, so writes to it simply vanish
  wire logic [15:0] next_ver_word = {NEXT_CAP_PTR, CAP_VERSION};
  wire logic [DATA_W-1:0] header_word = {next_ver_word, CAP_ID_VAL};
  wire logic [DATA_W-1:0] rd_mux =
    sel_header ? header_word :
    sel_flags ? (fif.flags & IMPL_BITS) :
    sel_masks ? (fif.masks & IMPL_BITS) : ZERO_WORD;

  logic cfg_ack_reg;
  logic cfg_hit_reg;
  logic [DATA_W-1:0] cfg_rdata_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ack_reg <= 1'b0;
      cfg_hit_reg <= 1'b0;
      cfg_rdata_reg <= ZERO_WORD;
    end else begin
      cfg_ack_reg <= cfg_req;
      cfg_hit_reg <= cfg_req & sel_any;
      cfg_rdata_reg <= (cfg_req & ~cfg_we) ? rd_mux : ZERO_WORD;
    end
  end

  assign cfg_ack = cfg_ack_reg;
  assign cfg_hit = cfg_hit_reg;
  assign cfg_rdata = cfg_rdata_reg;

  // ----------------------------------------------------------------------
  // Unmasked error reports
  // ----------------------------------------------------------------------
  // Feeds message, header log and first-error pointer logic elsewhere;
  // a masked source never reaches any of them.
  logic [DATA_W-1:0] report_reg;
  wire logic [DATA_W-1:0] report_next = fif.detect & ~fif.masks;

  always_ff @(posedge clk) begin
    if (reset | ~fund_n_reg) begin
      report_reg <= ZERO_WORD;
    end else begin
      report_reg <= report_next;
    end
  end

  assign error_report = report_reg;
endmodule : aerr_regs

`default_nettype wire

// [design/aerr_pkg.sv]
// Constants for the advanced error reporting header and the uncorrectable
// error status and mask registers.
// Assumes dword-wide configuration accesses into extended config space.
`default_nettype none

package aerr_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int LANE_W = 8;
  localparam int NUM_SRC = 10;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses in extended config space)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CAP_ID_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] NEXT_VER_OFS = 12'h102;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] MASKS_OFS = 12'h108;
  localparam logic [ADDR_W-1:0] RSVD_LO_OFS = 12'h14C;
  localparam logic [ADDR_W-1:0] RSVD_HI_OFS = 12'hFFC;
  localparam int DWORD_LSB = 2;

  // ----------------------------------------------------------------------
  // Read-only header values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CAP_ID_VAL = 16'h0001;
  localparam logic [11:0] NEXT_CAP_PTR = 12'h000;
  localparam logic [3:0] CAP_VERSION = 4'h1;

  // ----------------------------------------------------------------------
  // Field positions of status and mask bits
  // ----------------------------------------------------------------------
  localparam int LINK_PROTOCOL_BIT = 4;
  localparam int POISONED_PACKET_BIT = 12;
  localparam int FLOW_CONTROL_PROTOCOL_BIT = 13;
  localparam int COMPLETION_TIMEOUT_BIT = 14;
  localparam int COMPLETER_ABORT_BIT = 15;
  localparam int UNEXPECTED_COMPLETION_BIT = 16;
  localparam int CREDIT_OVERFLOW_BIT = 17;
  localparam int MALFORMED_PACKET_BIT = 18;
  localparam int END_TO_END_CRC_BIT = 19;
  localparam int UNSUPPORTED_REQUEST_BIT = 20;

  // Implemented bits; all others are reserved and read as zero
  localparam logic [DATA_W-1:0] IMPL_BITS = 32'h001FF010;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] MASKS_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
endpackage : aerr_pkg

`default_nettype wire

// [design/aerr_flag_if.sv]
// Carrier between the register front end and the sticky flag bank.
// Assumes both ends share one clock.
`default_nettype none

interface aerr_flag_if;
  import aerr_pkg::*;
  logic fund_clear;
  logic [DATA_W-1:0] detect;
  logic [DATA_W-1:0] clear_ones;
  logic [DATA_W-1:0] mask_wen;
  logic [DATA_W-1:0] mask_wdata;
  logic [DATA_W-1:0] flags;
  logic [DATA_W-1:0] masks;

  modport front (
    output fund_clear, detect, clear_ones, mask_wen, mask_wdata,
    input flags, masks
  );
  modport bank (
    input fund_clear, detect, clear_ones, mask_wen, mask_wdata,
    output flags, masks
  );
endinterface : aerr_flag_if

`default_nettype wire

// [design/aerr_flag_bank.sv]
// Sticky uncorrectable error flags and their suppress bits.
// Assumes clear and detect are one-cycle strobes from the same clock.
`default_nettype none

module aerr_flag_bank (
  input wire logic clk,
  aerr_flag_if.bank fb
);
  import aerr_pkg::*;

  // ----------------------------------------------------------------------
  // One cell per bit; reserved positions are constant zero
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    if (IMPL_BITS[i]) begin : g_impl
      logic flag_reg;
      logic flag_next;
      logic mask_reg;
      logic mask_next;
      wire logic set_hit = fb.detect[i] & ~mask_reg;
      // Set beats a simultaneous write-one clear so no event is lost
      assign flag_next = (flag_reg & ~fb.clear_ones[i]) | set_hit;
      assign mask_next = fb.mask_wen[i] ? fb.mask_wdata[i] : mask_reg;
      always_ff @(posedge clk) begin
        if (fb.fund_clear) begin
          flag_reg <= FLAGS_RESET[i];
          mask_reg <= MASKS_RESET[i];
        end else begin
          flag_reg <= flag_next;
          mask_reg <= mask_next;
        end
      end
      assign fb.flags[i] = flag_reg;
      assign fb.masks[i] = mask_reg;
    end else begin : g_rsvd
      assign fb.flags[i] = 1'b0;
      assign fb.masks[i] = 1'b0;
    end
  end
endmodule : aerr_flag_bank

`default_nettype wire

// [sim/aerr_chk_sva.sv]
// Port-level checker for the error reporting header and status/mask bank.
// Assumes one clock; hot reset disables the checks.
`default_nettype none

module aerr_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic pcie_reset_n,
  input wire logic global_reset_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_hit,
  input wire logic [31:0] cfg_rdata,
  input wire logic poisoned_packet_det,
  input wire logic link_protocol_det,
  input wire logic fundamental_reset_n,
  input wire logic [31:0] error_report,
  input wire logic [31:0] error_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import aerr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_hdr_rd;
    cfg_req && !cfg_we && cfg_addr[11:2] == CAP_ID_OFS[11:2];
  endsequence
  sequence s_flags_rd;
    cfg_req && !cfg_we && cfg_addr[11:2] == FLAGS_OFS[11:2];
  endsequence
  a_hdr_value: assert property (
    s_hdr_rd |=> cfg_hit && cfg_rdata == 32'h00010001) else $error("header read wrong");
  a_unmapped_zero: assert property (
    cfg_req && cfg_addr >= RSVD_LO_OFS |=> !cfg_hit && cfg_rdata == ZERO_WORD)
    else $error("reserved space answered");
  a_rsvd_flags: assert property ((error_flags & ~IMPL_BITS) == ZERO_WORD)
    else $error("reserved flag bit set");
  a_rsvd_rdata: assert property (
    cfg_req && cfg_addr[11:4] == 8'h10 && cfg_addr[3:2] != 2'h0
    |=> (cfg_rdata & ~IMPL_BITS) == ZERO_WORD) else $error("reserved read bit set");
  a_flags_read: assert property (s_flags_rd |=> cfg_rdata == $past(error_flags))
    else $error("status read differs from flags");
  a_report_cause: assert property (
    error_report[POISONED_PACKET_BIT] |-> $past(poisoned_packet_det))
    else $error("report without detect");
  a_report_flag: assert property ((error_report & ~error_flags) == ZERO_WORD)
    else $error("report without flag");
  a_link_cause: assert property (
    $rose(error_flags[LINK_PROTOCOL_BIT]) |-> $past(link_protocol_det))
    else $error("link flag rose alone");
  a_flag_sticky: assert property (
    |($past(error_flags) & ~error_flags)
    |-> $past(cfg_req && cfg_we) || !$past(fundamental_reset_n) || !fundamental_reset_n)
    else $error("flag dropped without clear");
  a_fundamental_reset_n_clear: assert property (!fundamental_reset_n |=> error_flags == ZERO_WORD)
    else $error("flags survive reset");
  a_fundamental_reset_n_follow: assert property (
    (!pcie_reset_n || !global_reset_n) [*6] |-> !fundamental_reset_n)
    else $error("fundamental reset not asserted");
endmodule : aerr_chk

`default_nettype wire

// [sim/aerr_rc_model.sv]
// Root complex model issuing dword configuration reads and writes.
// Assumes a one-cycle request strobe answered exactly one edge later.
`default_nettype none

module aerr_rc_model (
  input wire logic clk,
  output logic cfg_req,
  output logic cfg_we,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic cfg_hit,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  task automatic access(input logic we, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic hit,
                        output logic ok);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge clk);
    // Released address, byte-enable and data lines show inverted junk so stale values never look valid
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~be;
    cfg_wdata <= ~wd;
    @(posedge clk);
    ok = (cfg_ack === 1'b1);
    hit = cfg_hit;
    rd = cfg_rdata;
  endtask : access
endmodule : aerr_rc_model

`default_nettype wire

// [sim/test_pcie_aer_uncorrectable_regs.sv]
// Self-checking bench for the error header and status/mask registers.
// Assumes the root complex model answers every access; waits are bounded.
`default_nettype none

module test_pcie_aer_uncorrectable_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import aerr_pkg::*;
  localparam int POS [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
  logic clk = 0, reset = 1, pcie_reset_n = 0, global_reset_n = 0;
  logic [9:0] det = '0;
  logic cfg_req, cfg_we, cfg_ack, cfg_hit, fundamental_reset_n, h, ok;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, error_report, error_flags, d;
  int fails = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  aerr_rc_model rc (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
    .cfg_rdata(cfg_rdata));
  aerr_regs uut (.clk(clk), .reset(reset), .pcie_reset_n(pcie_reset_n),
    .global_reset_n(global_reset_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .unsupported_request_det(det[0]),
    .end_to_end_crc_det(det[1]), .malformed_packet_det(det[2]),
    .credit_overflow_det(det[3]), .unexpected_completion_det(det[4]),
    .completer_abort_det(det[5]), .completion_timeout_det(det[6]),
    .flow_control_protocol_det(det[7]), .poisoned_packet_det(det[8]),
    .link_protocol_det(det[9]), .fundamental_reset_n(fundamental_reset_n),
    .error_report(error_report), .error_flags(error_flags));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    rc.access(we, a, be, wd, d, h, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    if (ok !== 1'b1) end_sim();
  endtask : acc
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    det <= v;
    @(posedge clk);
    det <= '0;
  endtask : pulse
  task automatic wait_fund;
    for (int n = 0; n < 20 && fundamental_reset_n !== 1'b1; n++) @(posedge clk);
    chk("fundamental_reset_n_release", {31'h0, fundamental_reset_n}, 32'h1);
    if (fundamental_reset_n !== 1'b1) end_sim();
  endtask : wait_fund
  task automatic t_header;
    acc(1, CAP_ID_OFS, 4'hF, 32'hFFFFFFFF);
    acc(0, NEXT_VER_OFS, 4'hF, 0);
    chk("hdr", d, 32'h00010001);
    chk("hdr_hit", {31'h0, h}, 32'h1);
    acc(0, RSVD_LO_OFS, 4'hF, 0);
    chk("rsvd_lo", d | {31'h0, h}, 32'h0);
    acc(0, RSVD_HI_OFS, 4'hF, 0);
    chk("rsvd_hi", d | {31'h0, h}, 32'h0);
  endtask : t_header
  task automatic t_detect;
    for (int i = 0; i < 10; i++) begin
      pulse(10'h1 << i);
      @(posedge clk);
      chk("flag", error_flags, 32'h1 << POS[i]);
      chk("report", error_report, 32'h1 << POS[i]);
      acc(1, FLAGS_OFS, 4'hF, ~(32'h1 << POS[i]));
      chk("keep", error_flags, 32'h1 << POS[i]);
      acc(1, FLAGS_OFS, 4'hF, 32'h1 << POS[i]);
      chk("clear", error_flags, 32'h0);
    end
  endtask : t_detect
  task automatic t_mask;
    acc(1, MASKS_OFS, 4'h4, 32'hFFFFFFFF);
    acc(0, MASKS_OFS, 4'hF, 0);
    chk("lane", d, 32'h001F0000);
    acc(1, MASKS_OFS, 4'hF, 32'hFFFFFFFF);
    acc(0, MASKS_OFS, 4'hF, 0);
    chk("mask", d, IMPL_BITS);
    chk("mask_hit", {31'h0, h}, 32'h1);
    pulse(10'h3FF);
    @(posedge clk);
    chk("masked", error_flags | error_report, 32'h0);
    acc(1, MASKS_OFS, 4'hF, 0);
    pulse(10'h3FF);
    acc(0, FLAGS_OFS, 4'hF, 0);
    chk("all", d, IMPL_BITS);
    chk("flags_hit", {31'h0, h}, 32'h1);
  endtask : t_mask
  task automatic t_race;
    fork
      acc(1, FLAGS_OFS, 4'hF, 32'h00001000);
      pulse(10'h100);
    join
    chk("set_wins", {31'h0, error_flags[12]}, 32'h1);
  endtask : t_race
  task automatic t_reset;
    acc(1, MASKS_OFS, 4'h1, 32'hFFFFFFFF);
    @(posedge clk);
    reset <= 1;
    @(posedge clk);
    reset <= 0;
    acc(0, FLAGS_OFS, 4'hF, 0);
    chk("hot_flags", d, IMPL_BITS);
    acc(0, MASKS_OFS, 4'hF, 0);
    chk("hot_masks", d, 32'h00000010);
    for (int p = 0; p < 2; p++) begin
      pulse(10'h3FF);
      acc(1, MASKS_OFS, 4'h1, 32'hFFFFFFFF);
      {pcie_reset_n, global_reset_n} <= p ? 2'b01 : 2'b10;
      repeat (8) @(posedge clk);
      chk("fundamental_reset_n_low", {31'h0, fundamental_reset_n}, 32'h0);
      {pcie_reset_n, global_reset_n} <= 2'b11;
      wait_fund();
      acc(0, FLAGS_OFS, 4'hF, 0);
      chk("fundamental_reset_n_flags", d, 32'h0);
      acc(0, MASKS_OFS, 4'hF, 0);
      chk("fundamental_reset_n_masks", d, MASKS_RESET);
    end
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clk);
    reset <= 0;
    pcie_reset_n <= 1;
    global_reset_n <= 1;
    wait_fund();
    t_header();
    t_detect();
    t_mask();
    t_race();
    t_reset();
    end_sim();
  end
endmodule : test_pcie_aer_uncorrectable_regs

bind aerr_regs aerr_chk u_chk (.clk(clk), .reset(reset), .pcie_reset_n(pcie_reset_n),
  .global_reset_n(global_reset_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
  .cfg_addr(cfg_addr), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata),
  .poisoned_packet_det(poisoned_packet_det), .link_protocol_det(link_protocol_det),
  .fundamental_reset_n(fundamental_reset_n), .error_report(error_report),
  .error_flags(error_flags));

`default_nettype wire
